// file: core/bus_release_pkg.sv
package bus_release_pkg;

	// Bus unit states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ACTIVE = 6'h02,
		ST_RELEASED = 6'h04,
		ST_BACKOFF = 6'h08,
		ST_DRAIN = 6'h10,
		ST_HALT_CYCLE = 6'h20
	} bus_state_type;

	// Cycle type codes presented on the cycle type output
	localparam logic [1:0] CYC_NONE = 2'h0;
	localparam logic [1:0] CYC_NORMAL = 2'h1;
	localparam logic [1:0] CYC_HALT_ACK = 2'h2;

	// Synchroniser depth for the asynchronous halt request
	localparam int SYNC_STAGES = 2;

	// Reset values
	localparam logic RST_LOW = 1'h0;
	localparam logic RST_HIGH = 1'h1;

endpackage

// file: core/halt_req_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for the active-low halt request
module halt_req_sync
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Asynchronous level in, synchronous level out
	input wire logic async_n_i,
	output logic sync_n_o
);

	logic meta_n;
	logic stable_n;

	// Idle high so no request is seen during reset; first flop feeds only the second
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_n <= bus_release_pkg::RST_HIGH;
			stable_n <= bus_release_pkg::RST_HIGH;
		end
		else
		begin
			meta_n <= async_n_i;
			stable_n <= meta_n;
		end
	end

	assign sync_n_o = stable_n;

endmodule

`default_nettype wire

// file: core/bus_release_and_clock_stop.sv
// Behaviour
// R1 - On a halt request, stop issuing work at the next instruction boundary unless an interrupt wins.
// R2 - After halting, drain pipelines and write buffers, then run the halt-ack cycle.
// R3 - Halt request input is active low.
// R4 - Halt request is asynchronous and is synchronised before use.
// R5 - Requester holds the halt request until the halt-ack cycle is issued.
// R6 - Requester may drop the halt request any time after the halt-ack cycle.
// R7 - Internal bus need output is high whenever the core wants the bus.
// R8 - Internal bus need is active high and always driven.
// R9 - On hold request, float the bus pins.
// R10 - Grant hold only after the current cycle, burst or locked sequence ends.
// R11 - Stay released while hold request stays high.
// R12 - Hold request input is active high.
// R13 - Surrender ack rises in the same cycle the bus floats.
// R14 - Surrender ack falls when the bus is taken back.
// R15 - Surrender ack is active high and stays driven while floated.
// R16 - Forced release floats the bus in the next cycle without waiting.
// R17 - Forced release floats the same pins as hold but gives no ack.
// R18 - Forced release wins over a ready arriving in the same cycle.
// R19 - Stay off the bus until forced release is removed.
// R20 - A cycle cut by forced release restarts from its start afterwards.
// R21 - Forced release input is active low.
// R22 - The halt-ack cycle has its own type and ends on ready.
`timescale 1ns/1ps
`default_nettype none

module bus_release_and_clock_stop
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Core side
	input wire logic core_req_i,
	input wire logic core_burst_i,
	input wire logic core_lock_i,
	input wire logic instr_boundary_i,
	input wire logic irq_pending_i,
	input wire logic drain_empty_i,
	output logic core_halted_o,
	output logic cycle_done_o,
	// Arbitration and readiness pins
	input wire logic clock_halt_request_n_i,
	input wire logic hold_request_i,
	input wire logic forced_bus_release_n_i,
	input wire logic cycle_ready_n_i,
	input wire logic burst_ready_n_i,
	// Bus side outputs
	output logic internal_bus_need_o,
	output logic bus_surrender_ack_o,
	output logic bus_drive_oe_n_o,
	output logic cycle_start_o,
	output logic [1:0] cycle_type_o
);

	bus_release_pkg::bus_state_type state;
	bus_release_pkg::bus_state_type next_state;
	logic halt_req_n;
	logic halt_pend;
	logic next_halt_pend;
	logic backoff_restart;
	logic next_backoff_restart;
	logic core_halted;
	logic next_core_halted;
	logic internal_bus_need;
	logic bus_surrender_ack;
	logic bus_drive_oe_n;
	logic cycle_start;
	logic cycle_done;
	logic [1:0] cycle_type;
	logic [1:0] next_cycle_type;

	halt_req_sync u_sync
	(
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.async_n_i(clock_halt_request_n_i),
		.sync_n_o(halt_req_n)
	);

	// Decoded pin levels
	wire halt_req = !halt_req_n; // R3 R4
	wire backoff = !forced_bus_release_n_i; // R21
	wire hold_req = hold_request_i; // R12
	wire ready_seen = !cycle_ready_n_i || !burst_ready_n_i;
	// Burst and locked sequences keep the bus past a single ready
	wire seq_done = ready_seen && !core_burst_i && !core_lock_i;
	wire in_active = state == bus_release_pkg::ST_ACTIVE;
	wire in_halt_cycle = state == bus_release_pkg::ST_HALT_CYCLE;
	// A halt is taken only at a boundary and only if no interrupt outranks it
	wire halt_take = halt_pend && instr_boundary_i && !irq_pending_i; // R1
	wire want_bus = core_req_i || halt_pend || backoff_restart || in_active || in_halt_cycle;

	// Latch the halt request so later withdrawal is harmless
	always_comb
	begin
		next_halt_pend = halt_pend;
		if (halt_req && !core_halted)
			next_halt_pend = 1'h1;
		if (in_halt_cycle && ready_seen && !backoff)
			next_halt_pend = 1'h0; // R6
	end

	// Bus state sequencing; forced release overrides every other exit
	always_comb
	begin
		next_state = state;
		next_backoff_restart = backoff_restart;
		next_core_halted = core_halted;
		next_cycle_type = cycle_type;
		if (core_halted && !halt_req)
			next_core_halted = 1'h0; // R6
		case (state)
			bus_release_pkg::ST_IDLE:
			begin
				next_cycle_type = bus_release_pkg::CYC_NONE;
				if (backoff)
					next_state = bus_release_pkg::ST_BACKOFF; // R16
				else if (hold_req)
					next_state = bus_release_pkg::ST_RELEASED; // R9
				else if (halt_take)
					next_state = bus_release_pkg::ST_DRAIN; // R1
				else if ((core_req_i && !core_halted) || backoff_restart)
				begin
					next_state = bus_release_pkg::ST_ACTIVE;
					next_cycle_type = bus_release_pkg::CYC_NORMAL;
					next_backoff_restart = 1'h0; // R20
				end
			end
			bus_release_pkg::ST_ACTIVE:
			begin
				if (backoff)
				begin
					next_state = bus_release_pkg::ST_BACKOFF; // R16 R18
					next_backoff_restart = 1'h1; // R20
				end
				else if (seq_done)
				begin
					next_state = bus_release_pkg::ST_IDLE; // R10
					next_cycle_type = bus_release_pkg::CYC_NONE;
				end
			end
			bus_release_pkg::ST_RELEASED:
			begin
				if (backoff)
					next_state = bus_release_pkg::ST_BACKOFF;
				else if (!hold_req)
					next_state = bus_release_pkg::ST_IDLE; // R11 R14
			end
			bus_release_pkg::ST_BACKOFF:
			begin
				if (!backoff)
					next_state = bus_release_pkg::ST_IDLE; // R19
			end
			bus_release_pkg::ST_DRAIN:
			begin
				if (backoff)
					next_state = bus_release_pkg::ST_BACKOFF;
				else if (drain_empty_i)
				begin
					next_state = bus_release_pkg::ST_HALT_CYCLE; // R2
					next_cycle_type = bus_release_pkg::CYC_HALT_ACK; // R22
				end
			end
			bus_release_pkg::ST_HALT_CYCLE:
			begin
				if (backoff)
				begin
					next_state = bus_release_pkg::ST_BACKOFF; // R18
					next_cycle_type = bus_release_pkg::CYC_NONE;
				end
				else if (ready_seen)
				begin
					next_state = bus_release_pkg::ST_IDLE; // R22
					next_cycle_type = bus_release_pkg::CYC_NONE;
					next_core_halted = 1'h1;
				end
			end
			default:
			begin
				next_state = bus_release_pkg::ST_IDLE;
				next_cycle_type = bus_release_pkg::CYC_NONE;
			end
		endcase
	end

	// Float, ack and start decode from the next state, so registered outputs line up with it; done decodes from the current state
	wire next_floated = next_state == bus_release_pkg::ST_RELEASED || next_state == bus_release_pkg::ST_BACKOFF;
	wire next_ack = next_state == bus_release_pkg::ST_RELEASED; // R13 R17
	wire next_start = (next_state == bus_release_pkg::ST_ACTIVE || next_state == bus_release_pkg::ST_HALT_CYCLE)
		&& next_state != state;
	wire next_done = (in_active && seq_done && !backoff) || (in_halt_cycle && ready_seen && !backoff); // R18

	// State and bookkeeping registers
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state <= bus_release_pkg::ST_IDLE;
			halt_pend <= bus_release_pkg::RST_LOW;
			backoff_restart <= bus_release_pkg::RST_LOW;
			core_halted <= bus_release_pkg::RST_LOW;
			cycle_type <= bus_release_pkg::CYC_NONE;
		end
		else
		begin
			state <= next_state;
			halt_pend <= next_halt_pend;
			backoff_restart <= next_backoff_restart;
			core_halted <= next_core_halted;
			cycle_type <= next_cycle_type;
		end
	end

	// Registered pin outputs; need is driven in every state, never floated
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			internal_bus_need <= bus_release_pkg::RST_LOW;
			bus_surrender_ack <= bus_release_pkg::RST_LOW;
			bus_drive_oe_n <= bus_release_pkg::RST_LOW;
			cycle_start <= bus_release_pkg::RST_LOW;
			cycle_done <= bus_release_pkg::RST_LOW;
		end
		else
		begin
			internal_bus_need <= want_bus; // R7 R8
			bus_surrender_ack <= next_ack; // R13 R14 R15
			bus_drive_oe_n <= next_floated; // R9 R17
			cycle_start <= next_start; // R20
			cycle_done <= next_done;
		end
	end

	assign internal_bus_need_o = internal_bus_need;
	assign bus_surrender_ack_o = bus_surrender_ack;
	assign bus_drive_oe_n_o = bus_drive_oe_n;
	assign cycle_start_o = cycle_start;
	assign cycle_done_o = cycle_done;
	assign cycle_type_o = cycle_type;
	assign core_halted_o = core_halted;

	// Checks
	property p_backoff_float;
		@(posedge clk_i) disable iff (!arst_n_i)
		backoff |=> bus_drive_oe_n && !bus_surrender_ack;
	endproperty
	a_backoff_float: assert property (p_backoff_float) else $error("forced release did not float bus"); // R16

	property p_ack_with_float;
		@(posedge clk_i) disable iff (!arst_n_i)
		bus_surrender_ack |-> bus_drive_oe_n;
	endproperty
	a_ack_with_float: assert property (p_ack_with_float) else $error("ack without floated bus"); // R13

	property p_hold_stays;
		@(posedge clk_i) disable iff (!arst_n_i)
		bus_surrender_ack && hold_req && !backoff |=> bus_surrender_ack;
	endproperty
	a_hold_stays: assert property (p_hold_stays) else $error("released early during hold"); // R11

	property p_ack_drop;
		@(posedge clk_i) disable iff (!arst_n_i)
		bus_surrender_ack && !hold_req |=> !bus_surrender_ack;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack not dropped after hold removed"); // R14

	property p_no_grant_midcycle;
		@(posedge clk_i) disable iff (!arst_n_i)
		in_active && !seq_done && !backoff |=> !bus_surrender_ack;
	endproperty
	a_no_grant_midcycle: assert property (p_no_grant_midcycle) else $error("hold granted mid cycle"); // R10

	property p_backoff_wins;
		@(posedge clk_i) disable iff (!arst_n_i)
		backoff && ready_seen |=> !cycle_done;
	endproperty
	a_backoff_wins: assert property (p_backoff_wins) else $error("ready taken under forced release"); // R18

	property p_restart;
		@(posedge clk_i) disable iff (!arst_n_i)
		state == bus_release_pkg::ST_BACKOFF && backoff_restart && !backoff ##1 !backoff && !hold_req && !halt_take
			|=> cycle_start;
	endproperty
	a_restart: assert property (p_restart) else $error("cut cycle not restarted"); // R20

	property p_halt_after_drain;
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(cycle_type == bus_release_pkg::CYC_HALT_ACK) |-> $past(drain_empty_i);
	endproperty
	a_halt_after_drain: assert property (p_halt_after_drain) else $error("halt cycle before drain"); // R2

	property p_need_driven;
		@(posedge clk_i) disable iff (!arst_n_i)
		in_active |=> internal_bus_need;
	endproperty
	a_need_driven: assert property (p_need_driven) else $error("bus need low while cycle active"); // R7

	c_hold: cover property (@(posedge clk_i) disable iff (!arst_n_i) $rose(bus_surrender_ack));
	c_backoff_restart: cover property (@(posedge clk_i) disable iff (!arst_n_i) in_active && backoff);
	c_halt_cycle: cover property (@(posedge clk_i) disable iff (!arst_n_i) in_halt_cycle && ready_seen);

endmodule

`default_nettype wire

// file: testbench/ready_partner.sv
`timescale 1ns/1ps
`default_nettype none

// Far-side bus agent: returns ready wait_i+1 cycles after the cycle's start pulse
module ready_partner
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Bus activity seen from the device
	input wire logic start_i,
	input wire logic float_i,
	input wire logic burst_i,
	input wire logic [3:0] wait_i,
	// Ready strobes, active low
	output logic cycle_ready_n_o,
	output logic burst_ready_n_o
);
	logic busy;
	logic rdy;
	logic [3:0] cnt;

	// Floated bus kills the transfer, so no stale ready follows it
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			busy <= 1'b0;
		else if (float_i || (rdy && !burst_i))
			busy <= 1'b0;
		else if (start_i)
			busy <= 1'b1;
	end

	// Wait-state counter, reloaded after every ready
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cnt <= 4'h0;
		else if (!busy || rdy)
			cnt <= wait_i;
		else
			cnt <= cnt - 4'h1;
	end

	// Ready goes out on the strobe matching the transfer kind
	assign rdy = busy && (cnt == 4'h0);
	assign cycle_ready_n_o = !(rdy && !burst_i);
	assign burst_ready_n_o = !(rdy && burst_i);
endmodule
`default_nettype wire

// file: testbench/bus_release_and_clock_stop_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module bus_release_and_clock_stop_tb_top;
	logic clk_i = 1'b0;
	logic arst_n = 1'b0;
	logic req = 1'b0;
	logic burst = 1'b0;
	logic lock = 1'b0;
	logic bnd = 1'b0;
	logic irq = 1'b0;
	logic drn = 1'b1;
	logic halt_n = 1'b1;
	logic hold = 1'b0;
	logic forced_bus_release_n_n = 1'b1;
	logic rdy_n = 1'b1;
	logic [3:0] wt = 4'h0;
	logic p_rdy_n, p_burst_ready_n_n, halted, done, need, ack, oe_n, start;
	logic [1:0] ctype;
	int miscompares = 0;
	int n_checks = 0;
	wire [7:0] outs = {halted, done, need, ack, oe_n, start, ctype};

	always #5 clk_i = ~clk_i;

	bus_release_and_clock_stop dut (.clk_i(clk_i), .arst_n_i(arst_n), .core_req_i(req), .core_burst_i(burst),
		.core_lock_i(lock), .instr_boundary_i(bnd), .irq_pending_i(irq), .drain_empty_i(drn),
		.core_halted_o(halted), .cycle_done_o(done), .clock_halt_request_n_i(halt_n), .hold_request_i(hold),
		.forced_bus_release_n_i(forced_bus_release_n_n), .cycle_ready_n_i(p_rdy_n & rdy_n), .burst_ready_n_i(p_burst_ready_n_n),
		.internal_bus_need_o(need), .bus_surrender_ack_o(ack), .bus_drive_oe_n_o(oe_n),
		.cycle_start_o(start), .cycle_type_o(ctype));

	ready_partner partner (.clk_i(clk_i), .arst_n_i(arst_n), .start_i(start), .float_i(oe_n), .burst_i(burst),
		.wait_i(wt), .cycle_ready_n_o(p_rdy_n), .burst_ready_n_o(p_burst_ready_n_n));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// Bounded wait for a start (0), done (1) or ack (2)
	task automatic wait_for(input int sel);
		int k;
		k = 0;
		while (((sel == 0) ? start : (sel == 1) ? done : ack) !== 1'b1 && k < 40)
		begin
			cyc(1);
			k++;
		end
		chk(k < 40, 8'h01);
	endtask

	task automatic t_normal();
		req = 1'b1;
		wait_for(0);
		chk({start, need, ctype}, 8'h0D);
		req = 1'b0;
		wait_for(1);
	endtask

	task automatic t_hold_idle();
		hold = 1'b1;
		cyc(1);
		chk({ack, oe_n}, 8'h03);
		req = 1'b1;
		cyc(4);
		chk({ack, oe_n, need, start}, 8'h0E);
		hold = 1'b0;
		cyc(1);
		chk({ack, oe_n}, 8'h00);
		wait_for(0);
		req = 1'b0;
		wait_for(1);
	endtask

	// Hold must wait out a slow burst
	task automatic t_hold_burst();
		wt = 4'h3;
		burst = 1'b1;
		req = 1'b1;
		wait_for(0);
		req = 1'b0;
		hold = 1'b1;
		cyc(10);
		chk({ack, oe_n}, 8'h00);
		burst = 1'b0;
		wait_for(2);
		hold = 1'b0;
		wt = 4'h0;
		cyc(2);
	endtask

	// Locked sequence keeps the bus past a ready until the lock drops
	task automatic t_hold_lock();
		lock = 1'h1;
		req = 1'h1;
		wait_for(0);
		req = 1'h0;
		hold = 1'h1;
		cyc(4);
		chk({ack, oe_n, done}, 8'h00);
		lock = 1'h0;
		rdy_n = 1'h0;
		cyc(1);
		rdy_n = 1'h1;
		chk({ack, oe_n, done}, 8'h01);
		wait_for(2);
		chk({ack, oe_n}, 8'h03);
		hold = 1'h0;
		cyc(2);
	endtask

	// Reset in mid-run drops a granted hold at once
	task automatic t_reset_mid();
		hold = 1'h1;
		cyc(2);
		chk({ack, oe_n}, 8'h03);
		arst_n = 1'h0;
		hold = 1'h0;
		cyc(1);
		chk(outs, 8'h00);
		arst_n = 1'h1;
		cyc(2);
		chk(outs, 8'h00);
	endtask

	// Back-off with a ready in the same clock, then restart
	task automatic t_backoff();
		wt = 4'h4;
		req = 1'b1;
		wait_for(0);
		req = 1'b0;
		cyc(1);
		forced_bus_release_n_n = 1'b0;
		rdy_n = 1'b0;
		cyc(1);
		rdy_n = 1'b1;
		chk({oe_n, ack, done}, 8'h04);
		cyc(4);
		chk({oe_n, ack, start, done}, 8'h08);
		forced_bus_release_n_n = 1'b1;
		wait_for(0);
		chk(ctype, 8'h01);
		wait_for(1);
		wt = 4'h0;
	endtask

	task automatic t_halt();
		irq = 1'b1;
		bnd = 1'b1;
		halt_n = 1'b0;
		cyc(8);
		chk({start, ctype, halted}, 8'h00);
		drn = 1'b0;
		irq = 1'b0;
		cyc(6);
		chk({start, ctype}, 8'h00);
		drn = 1'b1;
		wait_for(0);
		chk(ctype, 8'h02);
		wait_for(1);
		cyc(1);
		chk(halted, 8'h01);
		halt_n = 1'b1;
		cyc(5);
		chk(halted, 8'h00);
	endtask

	task automatic report_and_stop();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Tests take well under 1000 cycles
	initial
	begin
		#20000;
		miscompares++;
		report_and_stop();
	end

	initial
	begin
		cyc(20);
		chk(outs, 8'h00);
		arst_n = 1'b1;
		cyc(1);
		chk(outs, 8'h00);
		t_normal();
		t_hold_idle();
		t_hold_burst();
		t_hold_lock();
		t_backoff();
		t_halt();
		t_reset_mid();
		report_and_stop();
	end
endmodule
`default_nettype wire
